// ===== hw/isf_core.sv
// What this block does
// - each rotation axis gives a signed 16-bit sample
// - rotation range 250 to 2000 dps selectable
// - sample rate 8000 to 3.9 Hz, lowpass selectable
// - acceleration range 2g to 16g selectable
// - device is always slave, host is master
// - address select pin sets address low bit
// - per-axis self-test enables actuate the sensors
// - clock from oscillator or automatic source choice
// - latest samples readable any time, read only
// - fifo holds 1008 bytes, read over serial
// - only enabled data kinds enter the fifo
// - byte counter tracks fifo writes and reads
// - burst reads return successive fifo bytes
// - fifo stays readable in low-power acceleration mode
// - watermark compare raises the watermark interrupt
// - five interrupt events available
// - pin shape, latching and clearing programmable
// - per-source enables and readable status flags
// - temperature in data registers and fifo
// - eight power modes set sensor states
// - motion when filtered acceleration exceeds threshold
`timescale 1ns/1ps
`include "isf_map.svh"
`default_nettype none
module isf_core
	import isf_pkg::*;
#(
	parameter int FIFO_DEPTH = `ISF_FIFO_DEPTH,
	parameter int BASE_FAST_CYC = `ISF_BASE_FAST_CYC,
	parameter int BASE_SLOW_CYC = `ISF_BASE_SLOW_CYC,
	parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary value
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic serial_port_clock,
	input wire logic serial_port_cs_n,
	input wire logic serial_port_data_in,
	output logic serial_port_data_out,
	output logic serial_port_data_oe,
	input wire logic addr_lsb_select_pin,
	output logic [6:0] i2c_slave_addr,
	input wire logic frame_sync_input,
	input wire logic adc_valid,
	input wire logic [15:0] adc_rot_x,
	input wire logic [15:0] adc_rot_y,
	input wire logic [15:0] adc_rot_z,
	input wire logic [15:0] adc_acc_x,
	input wire logic [15:0] adc_acc_y,
	input wire logic [15:0] adc_acc_z,
	input wire logic [15:0] adc_temp,
	input wire logic gyro_osc_ok,
	output logic clk_src_gyro,
	output logic [2:0] rot_selftest_drive,
	output logic [2:0] acc_selftest_drive,
	output logic rot_drive_en,
	output logic rot_sense_en,
	output logic rot_duty_cycled,
	output logic acc_en,
	output logic acc_duty_cycled,
	output logic int_out,
	output logic int_oe,
	output logic sample_ready_output_pin
);
	if (FIFO_DEPTH < 16 || FIFO_DEPTH > 1023) begin : g_bad_depth
		$error("fifo depth out of range");
	end
	if (BASE_FAST_CYC < 2 || BASE_FAST_CYC > 65536 ||
		BASE_SLOW_CYC < 2 || BASE_SLOW_CYC > 65536) begin : g_bad_base
		$error("base tick count out of range");
	end

	// ---------------- serial link domain ----------------
	logic [2:0] bit_cnt_reg;
	logic [6:0] sh_in_reg;
	logic first_reg;
	logic byte_tgl_reg;
	logic [7:0] byte_reg;
	logic byte_first_reg;
	logic [7:0] sh_out_reg;
	logic [7:0] rd_hold_reg;

	// bit capture on the rising edge; chip select high clears the frame
	always_ff @(posedge serial_port_clock or posedge serial_port_cs_n) begin
		if (serial_port_cs_n) begin
			bit_cnt_reg <= 3'h0;
			sh_in_reg <= 7'h00;
			first_reg <= 1'b1;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			sh_in_reg <= {sh_in_reg[5:0], serial_port_data_in};
			if (bit_cnt_reg == 3'h7) first_reg <= 1'b0;
		end
	end

	// completed byte handed over by toggle; byte stays put for eight link clocks
	always_ff @(posedge serial_port_clock or posedge sys_rst) begin
		if (sys_rst) begin
			byte_tgl_reg <= 1'b0;
			byte_reg <= 8'h00;
			byte_first_reg <= 1'b0;
		end else if (!serial_port_cs_n && bit_cnt_reg == 3'h7) begin
			byte_tgl_reg <= ~byte_tgl_reg;
			byte_reg <= {sh_in_reg, serial_port_data_in};
			byte_first_reg <= first_reg;
		end
	end

	// read data loads at a byte boundary; host pauses the clock so rd_hold is settled
	always_ff @(negedge serial_port_clock or posedge serial_port_cs_n) begin
		if (serial_port_cs_n) sh_out_reg <= 8'h00;
		else if (bit_cnt_reg == 3'h0 && !first_reg) sh_out_reg <= rd_hold_reg;
		else sh_out_reg <= {sh_out_reg[6:0], 1'b0};
	end
	assign serial_port_data_out = sh_out_reg[7];
	assign serial_port_data_oe = ~serial_port_cs_n;

	// ---------------- system domain: pin synchronisers ----------------
	logic [1:0] tgl_sync_reg, cs_sync_reg, sa_sync_reg, fs_sync_reg, osc_sync_reg;
	logic tgl_seen_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tgl_sync_reg <= 2'b00;
			cs_sync_reg <= 2'b11;
			sa_sync_reg <= 2'b00;
			fs_sync_reg <= 2'b00;
			osc_sync_reg <= 2'b00;
			tgl_seen_reg <= 1'b0;
		end else begin
			tgl_sync_reg <= {tgl_sync_reg[0], byte_tgl_reg};
			cs_sync_reg <= {cs_sync_reg[0], serial_port_cs_n};
			sa_sync_reg <= {sa_sync_reg[0], addr_lsb_select_pin};
			fs_sync_reg <= {fs_sync_reg[0], frame_sync_input};
			osc_sync_reg <= {osc_sync_reg[0], gyro_osc_ok};
			tgl_seen_reg <= tgl_sync_reg[1];
		end
	end
	wire byte_evt = tgl_sync_reg[1] ^ tgl_seen_reg;
	assign i2c_slave_addr = {6'h34, sa_sync_reg[1]};

	// ---------------- registers ----------------
	logic [7:0] rate_div_reg, filter_reg, rot_st_reg, acc_st_reg, fifo_sel_reg;
	logic [7:0] wom_thr_reg [3];
	logic [7:0] int_cfg_reg, int_en_reg, int_stat_reg, intel_reg, pwr_reg;
	logic [9:0] wm_reg;
	logic [15:0] data_reg [7]; // acc x y z, temp, rot x y z
	logic [9:0] count_reg;
	logic [7:0] fifo_mem [FIFO_DEPTH];
	logic [9:0] wr_ptr_reg, rd_ptr_reg;

	isf_tx_t tx_reg;
	logic [6:0] addr_reg;
	logic fetch_due_reg, pend_pop_reg;
	wire wr_evt = byte_evt && tx_reg == ISF_TX_WRITE;
	wire do_fetch = fetch_due_reg;
	wire pop = byte_evt && tx_reg == ISF_TX_READ && pend_pop_reg && count_reg != 10'h000;

	// read mux; data registers read any time and never written
	logic [7:0] rd_mux;
	wire [6:0] data_off = addr_reg - `ISF_REG_DATA_FIRST; // even offset is the high byte
	always_comb begin
		rd_mux = 8'h00;
		if (addr_reg >= `ISF_REG_DATA_FIRST && addr_reg <= `ISF_REG_DATA_LAST) begin
			rd_mux = data_off[0] ? data_reg[data_off[3:1]][7:0] : data_reg[data_off[3:1]][15:8];
		end else begin
			case (addr_reg)
				`ISF_REG_RATE_DIV: rd_mux = rate_div_reg;
				`ISF_REG_FILTER: rd_mux = filter_reg;
				`ISF_REG_ROT_ST: rd_mux = rot_st_reg;
				`ISF_REG_ACC_ST: rd_mux = acc_st_reg;
				`ISF_REG_WOM_X: rd_mux = wom_thr_reg[0];
				`ISF_REG_WOM_Y: rd_mux = wom_thr_reg[1];
				`ISF_REG_WOM_Z: rd_mux = wom_thr_reg[2];
				`ISF_REG_FIFO_SEL: rd_mux = fifo_sel_reg;
				`ISF_REG_INT_CFG: rd_mux = int_cfg_reg;
				`ISF_REG_INT_EN: rd_mux = int_en_reg;
				`ISF_REG_INT_STAT: rd_mux = int_stat_reg;
				`ISF_REG_WM_HI: rd_mux = {6'h00, wm_reg[9:8]};
				`ISF_REG_WM_LO: rd_mux = wm_reg[7:0];
				`ISF_REG_INTEL: rd_mux = intel_reg;
				`ISF_REG_PWR: rd_mux = pwr_reg;
				`ISF_REG_CNT_HI: rd_mux = {6'h00, count_reg[9:8]};
				`ISF_REG_CNT_LO: rd_mux = count_reg[7:0];
				`ISF_REG_FIFO_DATA: rd_mux = count_reg != 10'h000 ? fifo_mem[rd_ptr_reg] : 8'h00;
				`ISF_REG_ID: rd_mux = DEVICE_ID;
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// transaction sequencer: first byte is direction and address, then data bytes
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_reg <= ISF_TX_IDLE;
			addr_reg <= 7'h00;
			fetch_due_reg <= 1'b0;
			pend_pop_reg <= 1'b0;
			rd_hold_reg <= 8'h00;
		end else begin
			fetch_due_reg <= 1'b0;
			if (do_fetch) begin
				rd_hold_reg <= rd_mux;
				// fifo address does not advance, so a burst walks the fifo
				pend_pop_reg <= addr_reg == `ISF_REG_FIFO_DATA;
				if (addr_reg != `ISF_REG_FIFO_DATA) addr_reg <= addr_reg + 7'h01;
			end
			if (cs_sync_reg[1]) begin
				tx_reg <= ISF_TX_IDLE;
				pend_pop_reg <= 1'b0;
			end else if (byte_evt) begin
				case (tx_reg)
					ISF_TX_IDLE: begin
						if (byte_first_reg) begin
							addr_reg <= byte_reg[6:0];
							tx_reg <= byte_reg[7] ? ISF_TX_READ : ISF_TX_WRITE;
							fetch_due_reg <= byte_reg[7];
						end
					end
					ISF_TX_READ: fetch_due_reg <= 1'b1; // previous byte went out, prefetch next
					ISF_TX_WRITE: if (addr_reg != `ISF_REG_FIFO_DATA) addr_reg <= addr_reg + 7'h01;
					default: tx_reg <= ISF_TX_IDLE;
				endcase
			end
		end
	end

	// software-written registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rate_div_reg <= `ISF_RST_ZERO;
			filter_reg <= `ISF_RST_ZERO;
			rot_st_reg <= `ISF_RST_ZERO;
			acc_st_reg <= `ISF_RST_ZERO;
			fifo_sel_reg <= `ISF_RST_ZERO;
			wom_thr_reg <= '{`ISF_RST_ZERO, `ISF_RST_ZERO, `ISF_RST_ZERO};
			int_cfg_reg <= `ISF_RST_ZERO;
			int_en_reg <= `ISF_RST_ZERO;
			intel_reg <= `ISF_RST_ZERO;
			pwr_reg <= `ISF_RST_PWR;
			wm_reg <= 10'h000;
		end else if (wr_evt) begin
			case (addr_reg)
				`ISF_REG_RATE_DIV: rate_div_reg <= byte_reg;
				`ISF_REG_FILTER: filter_reg <= byte_reg;
				`ISF_REG_ROT_ST: rot_st_reg <= byte_reg;
				`ISF_REG_ACC_ST: acc_st_reg <= byte_reg;
				`ISF_REG_WOM_X: wom_thr_reg[0] <= byte_reg;
				`ISF_REG_WOM_Y: wom_thr_reg[1] <= byte_reg;
				`ISF_REG_WOM_Z: wom_thr_reg[2] <= byte_reg;
				`ISF_REG_FIFO_SEL: fifo_sel_reg <= byte_reg;
				`ISF_REG_INT_CFG: int_cfg_reg <= byte_reg;
				`ISF_REG_INT_EN: int_en_reg <= byte_reg;
				`ISF_REG_WM_HI: wm_reg[9:8] <= byte_reg[1:0];
				`ISF_REG_WM_LO: wm_reg[7:0] <= byte_reg;
				`ISF_REG_INTEL: intel_reg <= byte_reg;
				`ISF_REG_PWR: pwr_reg <= byte_reg;
				default: wm_reg <= wm_reg; // read-only and unmapped writes are ignored
			endcase
		end
	end
	// self-test actuation goes straight to the sensing front end
	assign rot_selftest_drive = rot_st_reg[`ISF_ST_X -: 3];
	assign acc_selftest_drive = acc_st_reg[`ISF_ST_X -: 3];

	// ---------------- power modes and clock source ----------------
	isf_pmode_t pmode;
	logic rot_on, acc_on;
	assign pmode = isf_pmode_t'(pwr_reg[2:0]);
	always_comb begin
		rot_on = 1'b0;
		acc_on = 1'b0;
		case (pmode)
			ISF_PM_ACC_LP, ISF_PM_ACC_LN: acc_on = 1'b1;
			ISF_PM_ROT_LP, ISF_PM_ROT_LN: rot_on = 1'b1;
			ISF_PM_6AX_LN, ISF_PM_6AX_LP: begin
				rot_on = 1'b1;
				acc_on = 1'b1;
			end
			default: rot_on = 1'b0;
		endcase
	end
	assign rot_drive_en = rot_on || pmode == ISF_PM_STANDBY;
	assign rot_sense_en = rot_on;
	assign rot_duty_cycled = pmode == ISF_PM_ROT_LP || pmode == ISF_PM_6AX_LP;
	assign acc_en = acc_on;
	assign acc_duty_cycled = pmode == ISF_PM_ACC_LP; // fifo reads still served here

	// automatic choice takes the rotor oscillator only while it runs
	logic src_gyro_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) src_gyro_reg <= 1'b0;
		else src_gyro_reg <= pwr_reg[`ISF_PWR_AUTO] && osc_sync_reg[1] && rot_drive_en;
	end
	assign clk_src_gyro = src_gyro_reg;
	wire lock_evt = src_gyro_reg != (pwr_reg[`ISF_PWR_AUTO] && osc_sync_reg[1] && rot_drive_en);

	// ---------------- sample rate ----------------
	logic [15:0] base_cnt_reg;
	logic [7:0] div_cnt_reg;
	logic sample_tick;
	// base rate drops to 1 kHz when filtering is on, giving 3.9 Hz at divide 256
	wire [15:0] base_top = filter_reg[2:0] != 3'h0 ? 16'(BASE_SLOW_CYC - 1) : 16'(BASE_FAST_CYC - 1);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			base_cnt_reg <= 16'h0000;
			div_cnt_reg <= 8'h00;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			if (base_cnt_reg >= base_top) begin
				base_cnt_reg <= 16'h0000;
				if (div_cnt_reg >= rate_div_reg) begin
					div_cnt_reg <= 8'h00;
					sample_tick <= pmode != ISF_PM_SLEEP && pmode != ISF_PM_STANDBY;
				end else div_cnt_reg <= div_cnt_reg + 8'h01;
			end else base_cnt_reg <= base_cnt_reg + 16'h0001;
		end
	end

	// range select: saturating shift so the narrow range gives more counts
	function automatic logic [15:0] isf_scale(input logic [15:0] raw, input logic [1:0] fs);
		logic [18:0] wide;
		wide = 19'($signed(raw)) <<< (2'h3 - fs);
		if ($signed(wide) > 19'sh07FFF) return 16'h7FFF;
		if ($signed(wide) < -19'sh08000) return 16'h8000;
		return wide[15:0];
	endfunction

	// ---------------- per-channel lowpass and data registers ----------------
	wire [15:0] adc_in [7] = '{adc_acc_x, adc_acc_y, adc_acc_z, adc_temp,
		adc_rot_x, adc_rot_y, adc_rot_z};
	logic [15:0] filt_reg [7];
	logic [15:0] prev_acc_reg [3];
	logic [2:0] wom_hit;
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_chan
			wire signed [16:0] delta = 17'($signed(adc_in[gi])) - 17'($signed(filt_reg[gi]));
			wire signed [16:0] step = delta >>> filter_reg[2:0];
			wire ch_on = gi == 3 || (gi < 3 ? acc_on : rot_on);
			// one-pole lowpass, bypassed at setting zero
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) filt_reg[gi] <= 16'h0000;
				else if (adc_valid) filt_reg[gi] <= filter_reg[2:0] == 3'h0 ? adc_in[gi] :
					16'($signed(filt_reg[gi]) + step);
			end
			// publish the latest 16-bit signed sample at the output rate
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) data_reg[gi] <= 16'h0000;
				else if (sample_tick && ch_on) data_reg[gi] <= gi == 3 ? filt_reg[gi] :
					isf_scale(filt_reg[gi], gi < 3 ? acc_st_reg[`ISF_FS_HI:`ISF_FS_LO] :
					rot_st_reg[`ISF_FS_HI:`ISF_FS_LO]);
			end
		end
		for (gi = 0; gi < 3; gi++) begin : g_wom
			wire signed [16:0] hp = 17'($signed(data_reg[gi])) - 17'($signed(prev_acc_reg[gi]));
			wire [16:0] mag = hp[16] ? 17'(-hp) : 17'(hp);
			// difference of consecutive samples is the highpass value
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) prev_acc_reg[gi] <= 16'h0000;
				else if (sample_tick) prev_acc_reg[gi] <= data_reg[gi];
			end
			assign wom_hit[gi] = mag > {5'h00, wom_thr_reg[gi], 4'h0}
				&& int_en_reg[`ISF_IRQ_WOM_X + gi];
		end
	endgenerate

	// motion is judged one cycle after publish, when prev and data hold both samples
	logic judge_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) judge_reg <= 1'b0;
		else judge_reg <= sample_tick && acc_on;
	end
	wire wom_any = intel_reg[`ISF_INTEL_AND] ?
		(wom_hit == int_en_reg[`ISF_IRQ_WOM_X +: 3]) && int_en_reg[`ISF_IRQ_WOM_X +: 3] != 3'h0 :
		|wom_hit;
	wire wom_evt = judge_reg && intel_reg[`ISF_INTEL_EN] && wom_any;

	// ---------------- fifo fill ----------------
	logic [127:0] frame_reg;
	logic [15:0] slot_mask_reg;
	logic [4:0] slot_reg;
	// slots: acc 0..5, temp 6..7, rot 8..13, frame sync 14..15
	wire [15:0] slot_mask = {{2{fifo_sel_reg[`ISF_SEL_SYNC]}}, {6{fifo_sel_reg[`ISF_SEL_ROT]}},
		{2{fifo_sel_reg[`ISF_SEL_TEMP]}}, {6{fifo_sel_reg[`ISF_SEL_ACC]}}};
	wire push = slot_reg < 5'h10 && slot_mask_reg[slot_reg[3:0]];
	wire full = count_reg == 10'(FIFO_DEPTH);
	wire ovf_evt = push && full; // newest byte is dropped when full
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			frame_reg <= 128'h0;
			slot_mask_reg <= 16'h0000;
			slot_reg <= 5'h10;
		end else if (judge_reg) begin
			frame_reg <= {data_reg[0], data_reg[1], data_reg[2], data_reg[3],
				data_reg[4], data_reg[5], data_reg[6], 15'h0000, fs_sync_reg[1]};
			slot_mask_reg <= slot_mask;
			slot_reg <= 5'h00;
		end else if (slot_reg < 5'h10) begin
			frame_reg <= {frame_reg[119:0], 8'h00};
			slot_reg <= slot_reg + 5'h01;
		end
	end

	// storage and byte counter
	always_ff @(posedge clk_sys) begin
		if (push && !full) fifo_mem[wr_ptr_reg] <= frame_reg[127:120];
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= 10'h000;
			rd_ptr_reg <= 10'h000;
			count_reg <= 10'h000;
		end else begin
			if (push && !full) wr_ptr_reg <= wr_ptr_reg == 10'(FIFO_DEPTH - 1) ? 10'h000 : wr_ptr_reg + 10'h001;
			if (pop) rd_ptr_reg <= rd_ptr_reg == 10'(FIFO_DEPTH - 1) ? 10'h000 : rd_ptr_reg + 10'h001;
			count_reg <= count_reg + 10'(push && !full) - 10'(pop);
		end
	end

	// ---------------- interrupts ----------------
	wire wm_lvl = count_reg >= wm_reg;
	wire data_rdy_evt = judge_reg;
	logic [7:0] evt;
	always_comb begin
		evt = 8'h00;
		evt[`ISF_IRQ_DATA_RDY] = data_rdy_evt;
		evt[`ISF_IRQ_LOCK] = lock_evt;
		evt[`ISF_IRQ_WM] = wm_lvl;
		evt[`ISF_IRQ_OVF] = ovf_evt;
		evt[`ISF_IRQ_WOM_X +: 3] = {3{wom_evt}} & wom_hit;
	end
	wire stat_clr = do_fetch && (addr_reg == `ISF_REG_INT_STAT || int_cfg_reg[`ISF_CFG_ANY_CLR]);
	// sticky flags; an event in the clearing cycle survives
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) int_stat_reg <= `ISF_RST_ZERO;
		else int_stat_reg <= (stat_clr ? 8'h00 : int_stat_reg) | evt;
	end
	// latched mode follows flags, otherwise the pin pulses with the event
	wire pin_act = int_cfg_reg[`ISF_CFG_LATCH] ? |(int_stat_reg & int_en_reg) : |(evt & int_en_reg);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			int_out <= 1'b0;
			int_oe <= 1'b1;
			sample_ready_output_pin <= 1'b0;
		end else begin
			int_out <= int_cfg_reg[`ISF_CFG_OPEN_DRAIN] ? 1'b0 : pin_act ^ int_cfg_reg[`ISF_CFG_ACT_LOW];
			int_oe <= int_cfg_reg[`ISF_CFG_OPEN_DRAIN] ? pin_act : 1'b1;
			sample_ready_output_pin <= data_rdy_evt || (wm_lvl && int_en_reg[`ISF_IRQ_WM]);
		end
	end
endmodule
`default_nettype wire

// ===== hw/isf_map.svh
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH
// register offsets on the serial port
`define ISF_REG_RATE_DIV 7'h19
`define ISF_REG_FILTER 7'h1A
`define ISF_REG_ROT_ST 7'h1B
`define ISF_REG_ACC_ST 7'h1C
`define ISF_REG_WOM_X 7'h20
`define ISF_REG_WOM_Y 7'h21
`define ISF_REG_WOM_Z 7'h22
`define ISF_REG_FIFO_SEL 7'h23
`define ISF_REG_INT_CFG 7'h37
`define ISF_REG_INT_EN 7'h38
`define ISF_REG_INT_STAT 7'h3A
`define ISF_REG_DATA_FIRST 7'h3B
`define ISF_REG_DATA_LAST 7'h48
`define ISF_REG_WM_HI 7'h60
`define ISF_REG_WM_LO 7'h61
`define ISF_REG_INTEL 7'h69
`define ISF_REG_PWR 7'h6B
`define ISF_REG_CNT_HI 7'h72
`define ISF_REG_CNT_LO 7'h73
`define ISF_REG_FIFO_DATA 7'h74
`define ISF_REG_ID 7'h75
// reset values
`define ISF_RST_ZERO 8'h00
`define ISF_RST_PWR 8'h08
// field positions
`define ISF_ST_X 7
`define ISF_FS_HI 4
`define ISF_FS_LO 3
`define ISF_PWR_AUTO 3
`define ISF_SEL_ACC 3
`define ISF_SEL_ROT 4
`define ISF_SEL_TEMP 5
`define ISF_SEL_SYNC 6
`define ISF_CFG_ACT_LOW 7
`define ISF_CFG_OPEN_DRAIN 6
`define ISF_CFG_LATCH 5
`define ISF_CFG_ANY_CLR 4
`define ISF_INTEL_EN 7
`define ISF_INTEL_AND 0
// interrupt bits, shared by enable and status
`define ISF_IRQ_DATA_RDY 0
`define ISF_IRQ_LOCK 1
`define ISF_IRQ_WM 2
`define ISF_IRQ_OVF 3
`define ISF_IRQ_WOM_X 5
// timing
`define ISF_CLK_HZ 40000000
`define ISF_BASE_FAST_HZ 8000
`define ISF_BASE_SLOW_HZ 1000
`define ISF_BASE_FAST_CYC (`ISF_CLK_HZ / `ISF_BASE_FAST_HZ)
`define ISF_BASE_SLOW_CYC (`ISF_CLK_HZ / `ISF_BASE_SLOW_HZ)
`define ISF_FIFO_DEPTH 1008
`endif

// ===== hw/isf_pkg.sv
`default_nettype none
package isf_pkg;
	// serial transaction states, one-hot
	typedef enum logic [2:0] {
		ISF_TX_IDLE = 3'b001,
		ISF_TX_READ = 3'b010,
		ISF_TX_WRITE = 3'b100
	} isf_tx_t;
	// power mode field encoding, mode number minus one
	typedef enum logic [2:0] {
		ISF_PM_SLEEP = 3'h0,
		ISF_PM_STANDBY = 3'h1,
		ISF_PM_ACC_LP = 3'h2,
		ISF_PM_ACC_LN = 3'h3,
		ISF_PM_ROT_LP = 3'h4,
		ISF_PM_ROT_LN = 3'h5,
		ISF_PM_6AX_LN = 3'h6,
		ISF_PM_6AX_LP = 3'h7
	} isf_pmode_t;
endpackage
`default_nettype wire

// ===== verification/isf_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the core, all on the system clock
module isf_core_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic serial_port_cs_n,
	input wire logic serial_port_data_out,
	input wire logic serial_port_data_oe,
	input wire logic addr_lsb_select_pin,
	input wire logic [6:0] i2c_slave_addr,
	input wire logic gyro_osc_ok,
	input wire logic clk_src_gyro,
	input wire logic rot_drive_en,
	input wire logic rot_sense_en,
	input wire logic rot_duty_cycled,
	input wire logic acc_en,
	input wire logic acc_duty_cycled
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// held long enough to pass the two-flop synchronisers
	sequence s_pin_held; $stable(addr_lsb_select_pin) [*5]; endsequence
	sequence s_osc_absent; !gyro_osc_ok [*5]; endsequence
	property p_addr_lsb; s_pin_held |-> i2c_slave_addr[0] == addr_lsb_select_pin; endproperty
	a_addr_lsb: assert property (p_addr_lsb) else $error("address lsb not following pin");
	property p_addr_hi; i2c_slave_addr[6:1] == 6'h34; endproperty
	a_addr_hi: assert property (p_addr_hi) else $error("fixed address bits wrong");
	property p_osc; s_osc_absent |-> !clk_src_gyro; endproperty
	a_osc: assert property (p_osc) else $error("absent oscillator chosen");
	property p_oe; serial_port_data_oe == !serial_port_cs_n; endproperty
	a_oe: assert property (p_oe) else $error("output enable not following select");
	// output shift is cleared while deselected, so no stale bit leaks out
	property p_dout_idle; serial_port_cs_n && $past(serial_port_cs_n) |-> !serial_port_data_out; endproperty
	a_dout_idle: assert property (p_dout_idle) else $error("data out active while idle");
	property p_sense; rot_sense_en |-> rot_drive_en; endproperty
	a_sense: assert property (p_sense) else $error("sensing without drive");
	property p_rot_dc; rot_duty_cycled |-> rot_sense_en && !acc_duty_cycled; endproperty
	a_rot_dc: assert property (p_rot_dc) else $error("bad rotation duty state");
	property p_acc_dc; acc_duty_cycled |-> acc_en && !rot_drive_en; endproperty
	a_acc_dc: assert property (p_acc_dc) else $error("bad accel duty state");
endmodule
`default_nettype wire

// ===== verification/isf_host.sv
`timescale 1ns/1ps
`default_nettype none
// host processor as clocked serial master; clock idles low between frames
module isf_host (
	output logic serial_port_clock,
	output logic serial_port_cs_n,
	output logic serial_port_data_in,
	input wire logic serial_port_data_out
);
	logic [7:0] tx_q [$];
	logic [7:0] rx_q [$];
	// idle state: deselected, clock low
	initial begin
		serial_port_clock = 1'b0;
		serial_port_cs_n = 1'b1;
		serial_port_data_in = 1'b0;
	end
	// header then n data bytes, 48 ns bit period, off the system clock grid
	task automatic frame(input logic [7:0] hdr, input int n);
		logic [7:0] sh;
		rx_q.delete();
		#7.3 serial_port_cs_n = 1'b0; // host masters, low picks clocked mode
		for (int b = 0; b <= n; b++) begin
			sh = (b == 0 || hdr[7]) ? hdr : tx_q.pop_front();
			for (int i = 7; i >= 0; i--) begin
				#24 serial_port_clock = 1'b0;
				serial_port_data_in = (b > 0 && hdr[7]) ? ~serial_port_data_in : sh[i];
				#24 serial_port_clock = 1'b1;
				sh[i] = serial_port_data_out;
			end
			rx_q.push_back(sh);
			// turnaround: the device needs time to fetch the next read byte
			if (hdr[7]) begin
				#250 serial_port_clock = 1'b0;
				#250;
			end
		end
		#24 serial_port_clock = 1'b0;
		#40 serial_port_cs_n = 1'b1;
		serial_port_data_in = ~serial_port_data_in;
		#150;
	endtask
endmodule
`default_nettype wire

// ===== verification/isf_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module isf_core_tb;
	logic clk_sys, sys_rst, serial_port_clock, serial_port_cs_n, serial_port_data_in;
	logic serial_port_data_out, serial_port_data_oe, addr_lsb_select_pin, frame_sync_input;
	logic adc_valid, gyro_osc_ok, clk_src_gyro, int_out, int_oe, sample_ready_output_pin;
	logic rot_drive_en, rot_sense_en, rot_duty_cycled, acc_en, acc_duty_cycled;
	logic [6:0] i2c_slave_addr;
	logic [2:0] rot_selftest_drive, acc_selftest_drive;
	logic [15:0] adc_rot_x, adc_rot_y, adc_rot_z, adc_acc_x, adc_acc_y, adc_acc_z, adc_temp, cnt;
	logic [63:0] smp = 64'h1234_A55A_0F0F_7E81;
	// expected {drive, sense, rotation duty, accel on, accel duty} for modes 1 to 8
	logic [4:0] pm [8] = '{5'h00, 5'h10, 5'h03, 5'h02, 5'h1C, 5'h18, 5'h1A, 5'h1E};
	logic [4:0] pwr_seen;
	int miscompares = 0;
	int samples_checked = 0;
	assign pwr_seen = {rot_drive_en, rot_sense_en, rot_duty_cycled, acc_en, acc_duty_cycled};
	// short base periods keep sample ticks close; the id value is arbitrary
	isf_core #(.BASE_FAST_CYC(20), .BASE_SLOW_CYC(40), .DEVICE_ID(8'hC3)) isf_core_inst (.*);
	isf_host isf_host_inst (.*);
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// register access over the serial port, realigned to the clock afterwards
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		isf_host_inst.tx_q.push_back(d);
		isf_host_inst.frame({1'b0, a}, 1);
		tick(1);
	endtask
	task automatic rd(input logic [6:0] a, input int n);
		isf_host_inst.frame({1'b1, a}, n);
		tick(1);
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// converter strobe every other cycle
	initial begin
		adc_valid = 1'b0;
		forever begin
			@(posedge clk_sys);
			#1 adc_valid = ~adc_valid;
		end
	end
	// a hang ends as a failure, not a stuck run
	initial begin
		#1000000;
		miscompares++;
		end_of_test();
	end
	initial begin
		sys_rst = 1'b1;
		{addr_lsb_select_pin, frame_sync_input, gyro_osc_ok} = 3'h0;
		{adc_acc_x, adc_acc_y, adc_acc_z, adc_temp} = 64'h0;
		{adc_rot_x, adc_rot_y, adc_rot_z} = 48'h0;
		tick(3);
		sys_rst = 1'b0;
		tick(3);
		rd(7'h75, 1);
		chk("id", isf_host_inst.rx_q[1], 16'hC3);
		rd(7'h1B, 2);
		chk("selftest reset", {isf_host_inst.rx_q[1], isf_host_inst.rx_q[2]}, 16'h0);
		wr(7'h1B, 8'hF8);
		wr(7'h1C, 8'hB8);
		rd(7'h1B, 2);
		chk("selftest regs", {isf_host_inst.rx_q[1], isf_host_inst.rx_q[2]}, 16'hF8B8);
		chk("selftest drive", {rot_selftest_drive, acc_selftest_drive}, 16'h3D);
		for (int m = 0; m < 8; m++) begin
			wr(7'h6B, 8'h08 | 8'(m));
			chk("power mode", pwr_seen, pm[m]);
		end
		wr(7'h6B, 8'h0E);
		chk("osc absent", clk_src_gyro, 1'b0);
		gyro_osc_ok = 1'b1;
		tick(8);
		chk("osc chosen", clk_src_gyro, 1'b1);
		for (int p = 0; p < 2; p++) begin
			addr_lsb_select_pin = p[0];
			tick(4);
			chk("slave addr", i2c_slave_addr, {6'h34, p[0]});
		end
		// accel and temperature only, full range so words pass unscaled
		{adc_acc_x, adc_acc_y, adc_acc_z, adc_temp} = smp;
		{adc_rot_x, adc_rot_y, adc_rot_z} = 48'h0102_0304_0506;
		wr(7'h23, 8'h28);
		tick(200);
		wr(7'h23, 8'h00);
		wr(7'h6B, 8'h0A);
		rd(7'h72, 2);
		cnt = {isf_host_inst.rx_q[1], isf_host_inst.rx_q[2]};
		chk("whole frames", {cnt[2:0], cnt != 16'h0}, 4'h1);
		wr(7'h60, cnt[15:8]);
		wr(7'h61, cnt[7:0]);
		wr(7'h38, 8'h04);
		tick(4);
		chk("wm pin", sample_ready_output_pin, 1'b1);
		chk("int pin", {int_oe, int_out}, 2'h3);
		rd(7'h3A, 1);
		chk("wm flag", isf_host_inst.rx_q[1] & 8'h04, 16'h04);
		rd(7'h74, 8);
		for (int i = 0; i < 8; i++) begin
			chk("fifo byte", isf_host_inst.rx_q[i + 1], smp[63 - 8 * i -: 8]);
		end
		rd(7'h72, 2);
		cnt = cnt - {isf_host_inst.rx_q[1], isf_host_inst.rx_q[2]};
		chk("count drop", cnt, 16'h8);
		// sleep stops sample ticks, so no ready pulse can mask the released level
		wr(7'h6B, 8'h08);
		chk("wm released", sample_ready_output_pin, 1'b0);
		chk("int idle", {int_oe, int_out}, 2'h2);
		rd(7'h3B, 8);
		for (int i = 0; i < 8; i++) begin
			chk("data reg", isf_host_inst.rx_q[i + 1], smp[63 - 8 * i -: 8]);
		end
		end_of_test();
	end
endmodule
bind isf_core isf_core_asserts isf_core_asserts_inst (.*);
`default_nettype wire
